// ---- rtl/pis_byte_reg.sv ----
// One host-writable byte register with a reset value.
// Assumes a synchronous, active-high reset and a one-cycle write strobe.
module pis_byte_reg import pis_pkg::*; #(
   parameter pis_byte_t RESET = 8'h00
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Write side
   input wire logic we,
   input wire pis_byte_t wdata,
   // Stored value
   output pis_byte_t q
);
   pis_byte_t q_r;
   pis_byte_t q_nxt;

   // Hold unless written
   always_comb begin
      q_nxt = we ? wdata : q_r;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         q_r <= RESET;
      end else begin
         q_r <= q_nxt;
      end
   end

   assign q = q_r;
endmodule

// ---- rtl/pis_map.svh ----
// Offsets, field positions, reset values and fixed codes of the paged
// identity and status register bank.
// Assumes the includer compares offsets against an 8-bit byte address.
`ifndef PIS_MAP_SVH
`define PIS_MAP_SVH

// ****************************************
// Register offsets within a page
// ****************************************
`define PIS_OFF_PAGE 8'h01
`define PIS_OFF_PART_LO 8'h02
`define PIS_OFF_PART_HI 8'h03
`define PIS_OFF_SPEED 8'h04
`define PIS_OFF_SREV 8'h05
`define PIS_OFF_TOOL0 8'h06
`define PIS_OFF_TOOL1 8'h07
`define PIS_OFF_TOOL2 8'h08
`define PIS_OFF_TEMP 8'h09
`define PIS_OFF_PKG 8'h0A
`define PIS_OFF_TADDR 8'h0B
`define PIS_OFF_STATUS 8'h0C
`define PIS_OFF_FLAGS 8'h11
`define PIS_OFF_MASK 8'h17
`define PIS_PAGE_ZERO 8'h00

// ****************************************
// Status and flag bit positions
// ****************************************
`define PIS_BIT_CAL 0
`define PIS_BIT_LOSS 1
`define PIS_BIT_LOCK 3
`define PIS_BIT_TMO 5
`define PIS_FLAG_BITS 8'h2B

// ****************************************
// Reset values
// ****************************************
`define PIS_RST_PAGE 8'h00
`define PIS_RST_TOOL 8'h00
`define PIS_RST_TEMP 8'h00
`define PIS_RST_PKG 8'h01
`define PIS_RST_TADDR 8'h68
`define PIS_RST_MASK 8'hC0
`define PIS_READ_ZERO 8'h00

`endif

// ---- rtl/pis_pkg.sv ----
// Types shared by the paged identity and status register bank.
// Assumes nothing of its surroundings.
package pis_pkg;
   typedef logic [7:0] pis_byte_t;
   typedef logic [6:0] pis_bus_addr_t;
endpackage

// ---- rtl/pis_regbank.sv ----
// Page-zero register bank: page select, identity codes, tool version,
// target address, live internal status, sticky flags and their masks.
// Assumes a serial host engine presents byte accesses one per cycle at most,
// never a read and a write in the same cycle; status inputs are synchronous.
//
// Behaviour
// R1: Page select sits at offset 0x01 of every page; read returns it, write sets it.
// R2: Page select is eight bits, 7:0, reaching any of 256 pages.
// R3: Read-only 16-bit base part identifier, four BCD digits, low byte first.
// R4: Read-only speed class byte, 0..3 meaning A..D.
// R5: Read-only silicon revision byte, 0 meaning A, upward.
// R6: Writable tool version fields spread over three bytes.
// R7: Target address bits 6:2 from register, bits 1:0 from address-select pins.
// R8: Target address register is excluded from nonvolatile burning.
// R9: Status bit 0 high while internal calibration runs.
// R10: Status bit 1 high while the reference input shows no signal.
// R11: Status bit 3 high while locking to the reference input fails.
// R12: Status bit 5 high on a serial bus timeout error.
// R13: Each status bit has a sticky flag, cleared by writing zero.
// R14: A set mask bit keeps its flag from driving the interrupt.
// R15: Page select is zero after reset.
module pis_regbank import pis_pkg::*; #(
   // Identity codes; values arbitrary
   parameter logic [15:0] BASE_PART = 16'h1234,
   parameter pis_byte_t SPEED_CLASS = 8'h00,
   parameter pis_byte_t SILICON_REV = 8'h00
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Byte access from the serial host engine
   input wire pis_byte_t reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire pis_byte_t reg_wdata,
   output pis_byte_t reg_rdata,
   output logic reg_rvalid,
   output logic reg_burnable,
   // Bus address straps and result
   input wire logic address_select_pin_high,
   input wire logic address_select_pin_low,
   output pis_bus_addr_t bus_addr,
   // Live internal conditions
   input wire logic system_calibration_busy,
   input wire logic ref_input_signal_loss,
   input wire logic ref_input_lock_error,
   input wire logic smbus_timeout,
   // Page and interrupt
   output pis_byte_t page_sel,
   output logic irq_n
);
`include "pis_map.svh"

   // ****************************************
   // Decode
   // ****************************************
   logic pg0;
   logic wr0;
   pis_byte_t page_q;
   pis_byte_t tool0_q;
   pis_byte_t tool1_q;
   pis_byte_t tool2_q;
   pis_byte_t temp_q;
   pis_byte_t pkg_q;
   pis_byte_t taddr_q;
   pis_byte_t mask_q;
   pis_byte_t status_vec;
   pis_byte_t flag_vec;
   pis_byte_t flag_clr;

   // Page-zero registers answer only while page zero is selected
   assign pg0 = (page_q == `PIS_PAGE_ZERO);
   assign wr0 = reg_wr && pg0;

   // ****************************************
   // Writable bytes
   // ****************************************
   // Page select answers on every page, full byte wide, zero out of reset (see R1) (see R2) (see R15)
   pis_byte_reg #(.RESET(`PIS_RST_PAGE)) u_page (
      .clk(clk),
      .rst(rst),
      .we(reg_wr && reg_addr == `PIS_OFF_PAGE),
      .wdata(reg_wdata),
      .q(page_q)
   );

   // Tool version: special/revision, minor low, minor high/major/tool (see R6)
   pis_byte_reg #(.RESET(`PIS_RST_TOOL)) u_tool0 (
      .clk(clk),
      .rst(rst),
      .we(wr0 && reg_addr == `PIS_OFF_TOOL0),
      .wdata(reg_wdata),
      .q(tool0_q)
   );

   pis_byte_reg #(.RESET(`PIS_RST_TOOL)) u_tool1 (
      .clk(clk),
      .rst(rst),
      .we(wr0 && reg_addr == `PIS_OFF_TOOL1),
      .wdata(reg_wdata),
      .q(tool1_q)
   );

   pis_byte_reg #(.RESET(`PIS_RST_TOOL)) u_tool2 (
      .clk(clk),
      .rst(rst),
      .we(wr0 && reg_addr == `PIS_OFF_TOOL2),
      .wdata(reg_wdata),
      .q(tool2_q)
   );

   // Temperature class and package code are plain stored bytes
   pis_byte_reg #(.RESET(`PIS_RST_TEMP)) u_temp (
      .clk(clk),
      .rst(rst),
      .we(wr0 && reg_addr == `PIS_OFF_TEMP),
      .wdata(reg_wdata),
      .q(temp_q)
   );

   pis_byte_reg #(.RESET(`PIS_RST_PKG)) u_pkg (
      .clk(clk),
      .rst(rst),
      .we(wr0 && reg_addr == `PIS_OFF_PKG),
      .wdata(reg_wdata),
      .q(pkg_q)
   );

   // Target address, seven bits kept; bit 7 dropped on write
   pis_byte_reg #(.RESET(`PIS_RST_TADDR)) u_taddr (
      .clk(clk),
      .rst(rst),
      .we(wr0 && reg_addr == `PIS_OFF_TADDR),
      .wdata({1'b0, reg_wdata[6:0]}),
      .q(taddr_q)
   );

   // Interrupt masks; the two top bits come up set
   pis_byte_reg #(.RESET(`PIS_RST_MASK)) u_mask (
      .clk(clk),
      .rst(rst),
      .we(wr0 && reg_addr == `PIS_OFF_MASK),
      .wdata(reg_wdata),
      .q(mask_q)
   );

   assign page_sel = page_q;

   // ****************************************
   // Live status and sticky flags
   // ****************************************
   // Unused status positions read as zero
   always_comb begin
      status_vec = '0;
      status_vec[`PIS_BIT_CAL] = system_calibration_busy;  // see R9
      status_vec[`PIS_BIT_LOSS] = ref_input_signal_loss;   // see R10
      status_vec[`PIS_BIT_LOCK] = ref_input_lock_error;    // see R11
      status_vec[`PIS_BIT_TMO] = smbus_timeout;            // see R12
   end

   // Writing 0 clears a flag, writing 1 leaves it alone (see R13)
   assign flag_clr = (wr0 && reg_addr == `PIS_OFF_FLAGS) ? (~reg_wdata & `PIS_FLAG_BITS) : '0;

   pis_sticky #(.W(8)) u_flags (
      .clk(clk),
      .rst(rst),
      .set_in(status_vec),
      .clr_in(flag_clr),
      .flag(flag_vec)
   );

   // Any unmasked flag pulls the interrupt low (see R14)
   assign irq_n = ~|(flag_vec & ~mask_q);

   // Nonvolatile burn must skip the target address byte (see R8)
   assign reg_burnable = !(pg0 && reg_addr == `PIS_OFF_TADDR);

   // ****************************************
   // Read path and bus address
   // ****************************************
   pis_byte_t rdata_r;
   pis_byte_t rdata_nxt;
   logic rvalid_r;
   logic rvalid_nxt;
   pis_bus_addr_t baddr_r;
   pis_bus_addr_t baddr_nxt;

   // Read mux; other pages only show their page select, the rest reads zero
   always_comb begin
      rdata_nxt = rdata_r;
      rvalid_nxt = reg_rd;
      baddr_nxt = {taddr_q[6:2], address_select_pin_high, address_select_pin_low};  // see R7
      if (reg_rd) begin
         rdata_nxt = `PIS_READ_ZERO;
         if (reg_addr == `PIS_OFF_PAGE) begin
            rdata_nxt = page_q;  // see R1
         end else if (pg0) begin
            case (reg_addr)
               `PIS_OFF_PART_LO: rdata_nxt = BASE_PART[7:0];   // see R3
               `PIS_OFF_PART_HI: rdata_nxt = BASE_PART[15:8];  // see R3
               `PIS_OFF_SPEED: rdata_nxt = SPEED_CLASS;        // see R4
               `PIS_OFF_SREV: rdata_nxt = SILICON_REV;         // see R5
               `PIS_OFF_TOOL0: rdata_nxt = tool0_q;
               `PIS_OFF_TOOL1: rdata_nxt = tool1_q;
               `PIS_OFF_TOOL2: rdata_nxt = tool2_q;
               `PIS_OFF_TEMP: rdata_nxt = temp_q;
               `PIS_OFF_PKG: rdata_nxt = pkg_q;
               `PIS_OFF_TADDR: rdata_nxt = taddr_q;
               `PIS_OFF_STATUS: rdata_nxt = status_vec;
               `PIS_OFF_FLAGS: rdata_nxt = flag_vec;
               `PIS_OFF_MASK: rdata_nxt = mask_q;
               default: rdata_nxt = `PIS_READ_ZERO;
            endcase
         end
      end
   end

   // Registered read data keeps the serial shifter free of mux glitches
   always_ff @(posedge clk) begin
      if (rst) begin
         rdata_r <= `PIS_READ_ZERO;
         rvalid_r <= 1'b0;
         baddr_r <= '0;
      end else begin
         rdata_r <= rdata_nxt;
         rvalid_r <= rvalid_nxt;
         baddr_r <= baddr_nxt;
      end
   end

   assign reg_rdata = rdata_r;
   assign reg_rvalid = rvalid_r;
   assign bus_addr = baddr_r;

   // ****************************************
   // Checks
   // ****************************************
   property p_page_write;
      @(posedge clk) disable iff (rst)
      (reg_wr && reg_addr == `PIS_OFF_PAGE) |=> (page_sel == $past(reg_wdata));
   endproperty
   a_page_write: assert property (p_page_write) else $error("page select missed write"); // see R1

   property p_page_read;
      @(posedge clk) disable iff (rst)
      (reg_rd && reg_addr == `PIS_OFF_PAGE) |=> (reg_rvalid && reg_rdata == $past(page_sel));
   endproperty
   a_page_read: assert property (p_page_read) else $error("page readback wrong"); // see R2

   property p_part_id;
      @(posedge clk) disable iff (rst)
      (reg_rd && pg0 && reg_addr == `PIS_OFF_PART_HI) |=> (reg_rdata == BASE_PART[15:8]);
   endproperty
   a_part_id: assert property (p_part_id) else $error("part id high byte wrong"); // see R3

   property p_speed;
      @(posedge clk) disable iff (rst)
      (reg_rd && pg0 && reg_addr == `PIS_OFF_SPEED) |=> (reg_rdata == SPEED_CLASS);
   endproperty
   a_speed: assert property (p_speed) else $error("speed class wrong"); // see R4

   property p_srev;
      @(posedge clk) disable iff (rst)
      (reg_rd && pg0 && reg_addr == `PIS_OFF_SREV) |=> (reg_rdata == SILICON_REV);
   endproperty
   a_srev: assert property (p_srev) else $error("silicon revision wrong"); // see R5

   property p_tool;
      @(posedge clk) disable iff (rst)
      (wr0 && reg_addr == `PIS_OFF_TOOL2) |=> (tool2_q == $past(reg_wdata));
   endproperty
   a_tool: assert property (p_tool) else $error("tool version byte not stored"); // see R6

   property p_bus_addr;
      @(posedge clk) disable iff (rst)
      !$past(rst) |-> (bus_addr == {$past(taddr_q[6:2]), $past(address_select_pin_high),
                                    $past(address_select_pin_low)});
   endproperty
   a_bus_addr: assert property (p_bus_addr) else $error("bus address composition wrong"); // see R7

   property p_burn;
      @(posedge clk) disable iff (rst)
      (pg0 && reg_addr == `PIS_OFF_TADDR) |-> !reg_burnable;
   endproperty
   a_burn: assert property (p_burn) else $error("target address marked burnable"); // see R8

   property p_status_read;
      @(posedge clk) disable iff (rst)
      (reg_rd && pg0 && reg_addr == `PIS_OFF_STATUS) |=>
         (reg_rdata[0] == $past(system_calibration_busy) && reg_rdata[5] == $past(smbus_timeout));
   endproperty
   a_status_read: assert property (p_status_read) else $error("status byte wrong"); // see R9

   property p_flag_set;
      @(posedge clk) disable iff (rst)
      ref_input_signal_loss |=> flag_vec[1];
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("loss flag not latched"); // see R13

   property p_irq;
      @(posedge clk) disable iff (rst)
      (flag_vec[3] && !mask_q[3]) |-> !irq_n;
   endproperty
   a_irq: assert property (p_irq) else $error("unmasked flag did not raise interrupt"); // see R14

   property p_irq_quiet;
      @(posedge clk) disable iff (rst)
      ((flag_vec & ~mask_q) == 8'h00) |-> irq_n;
   endproperty
   a_irq_quiet: assert property (p_irq_quiet) else $error("masked flag raised interrupt"); // see R14

   property p_reset_page;
      @(posedge clk) disable iff (rst)
      $fell(rst) |-> (page_sel == `PIS_RST_PAGE);
   endproperty
   a_reset_page: assert property (p_reset_page) else $error("page not zero after reset"); // see R15

   // A latched flag may only drop through a host clear
   property p_flag_hold;
      @(posedge clk) disable iff (rst)
      1'b1 |=> ((flag_vec & $past(flag_vec & ~flag_clr)) == $past(flag_vec & ~flag_clr));
   endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("sticky flag dropped without a clear"); // see R13

   property p_flag_clear;
      @(posedge clk) disable iff (rst)
      (flag_clr != 8'h00) |=> ((flag_vec & $past(flag_clr & ~status_vec)) == 8'h00);
   endproperty
   a_flag_clear: assert property (p_flag_clear) else $error("flag survived a clear"); // see R13

   property p_rvalid;
      @(posedge clk) disable iff (rst)
      1'b1 |=> (reg_rvalid == $past(reg_rd));
   endproperty
   a_rvalid: assert property (p_rvalid) else $error("read valid not one cycle after strobe"); // see R1

   property p_hidden;
      @(posedge clk) disable iff (rst)
      (reg_rd && !pg0 && reg_addr != `PIS_OFF_PAGE) |=> (reg_rdata == `PIS_READ_ZERO);
   endproperty
   a_hidden: assert property (p_hidden) else $error("page-zero byte visible on another page"); // see R1

   property p_taddr_store;
      @(posedge clk) disable iff (rst)
      (wr0 && reg_addr == `PIS_OFF_TADDR) |=> (taddr_q == {1'b0, $past(reg_wdata[6:0])});
   endproperty
   a_taddr_store: assert property (p_taddr_store) else $error("target address byte not stored"); // see R7
endmodule

// ---- rtl/pis_sticky.sv ----
// Bank of sticky flags: set by a live level, cleared by the host.
// Assumes set and clear are sampled on the same clock edge.
module pis_sticky #(
   parameter int W = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Events and clears
   input wire logic [W-1:0] set_in,
   input wire logic [W-1:0] clr_in,
   // Latched flags
   output logic [W-1:0] flag
);
   logic [W-1:0] flag_r;
   logic [W-1:0] flag_nxt;

   // Set wins over a clear in the same cycle, so no event is lost
   always_comb begin
      flag_nxt = (flag_r & ~clr_in) | set_in;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         flag_r <= '0;
      end else begin
         flag_r <= flag_nxt;
      end
   end

   assign flag = flag_r;
endmodule

// ---- tb/pis_host_model.sv ----
// Behavioural serial host engine issuing byte reads and writes.
// Assumes its tasks are called just after a rising clock edge.
module pis_host_model import pis_pkg::*; (
   // Clock
   input wire logic clk,
   // Byte access towards the bank
   output pis_byte_t reg_addr,
   output logic reg_wr,
   output logic reg_rd,
   output pis_byte_t reg_wdata,
   input wire pis_byte_t reg_rdata,
   input wire logic reg_rvalid
);
   timeunit 1ns;
   timeprecision 100ps;

   // ****************************************
   // Idle levels
   // ****************************************
   initial begin
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 8'h00;
   end

   // ****************************************
   // Access tasks
   // ****************************************
   // Lines not in use show the inverse, so stale values never look valid
   task automatic wr(input pis_byte_t a, input pis_byte_t d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge clk);
      #1;
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
      @(posedge clk);
      #1;
   endtask

   // Data and valid are sampled in the cycle after the taking edge
   task automatic rd(input pis_byte_t a, output pis_byte_t d, output logic v);
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge clk);
      #1;
      d = reg_rdata;
      v = reg_rvalid;
      reg_rd = 1'b0;
      reg_addr = ~a;
      @(posedge clk);
      #1;
   endtask

   // Present an address without a strobe
   task automatic aim(input pis_byte_t a);
      reg_addr = a;
   endtask
endmodule

// ---- tb/test_pis_regbank.sv ----
// Self-checking bench for the paged identity and status register bank.
// Assumes the host model drives all byte accesses; 125 MHz clock.
`include "pis_map.svh"
module test_pis_regbank import pis_pkg::*; ;
   timeunit 1ns;
   timeprecision 100ps;

   logic clk, rst, reg_wr, reg_rd, reg_rvalid, reg_burnable, irq_n;
   pis_byte_t reg_addr, reg_wdata, reg_rdata, page_sel, bit_v;
   pis_bus_addr_t bus_addr;
   logic [1:0] pins;
   logic [3:0] cond;
   int errors = 0;
   int comparisons = 0;
   int cycles = 0;
   int pos[4] = '{0, 1, 3, 5};
   // Identity codes below are arbitrary
   pis_byte_t ro_exp[4] = '{8'h68, 8'h24, 8'h02, 8'h03};
   pis_byte_t tool_val[3] = '{8'hA5, 8'h5A, 8'hFF};

   // ****************************************
   // Instances
   // ****************************************
   pis_regbank #(.BASE_PART(16'h2468), .SPEED_CLASS(8'h02), .SILICON_REV(8'h03)) i_pis_regbank (
      .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .reg_burnable(reg_burnable), .address_select_pin_high(pins[1]),
      .address_select_pin_low(pins[0]), .bus_addr(bus_addr),
      .system_calibration_busy(cond[0]), .ref_input_signal_loss(cond[1]),
      .ref_input_lock_error(cond[2]), .smbus_timeout(cond[3]), .page_sel(page_sel), .irq_n(irq_n));
   pis_host_model host (
      .clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

   // ****************************************
   // Clock and watchdog
   // ****************************************
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // Far above the 177 cycles the run needs
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         errors++;
         print_verdict();
      end
   end

   // ****************************************
   // Checking tasks
   // ****************************************
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask

   // Read one byte; valid must accompany it
   task automatic rchk(input pis_byte_t a, input pis_byte_t exp);
      pis_byte_t d;
      logic v;
      host.rd(a, d, v);
      chk({7'h00, v}, 8'h01);
      chk(d, exp);
   endtask

   task automatic print_verdict();
      if (errors == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // ****************************************
   // Test sequence
   // ****************************************
   initial begin
      rst = 1'b1;
      pins = 2'b00;
      cond = 4'h0;
      repeat (4) @(posedge clk);
      #1;
      rst = 1'b0;
      // Reset values
      rchk(`PIS_OFF_PAGE, `PIS_RST_PAGE);
      chk(page_sel, 8'h00);
      rchk(`PIS_OFF_TADDR, `PIS_RST_TADDR);
      rchk(`PIS_OFF_PKG, `PIS_RST_PKG);
      rchk(`PIS_OFF_TEMP, `PIS_RST_TEMP);
      rchk(`PIS_OFF_STATUS, 8'h00);
      rchk(`PIS_OFF_FLAGS, 8'h00);
      rchk(`PIS_OFF_MASK, `PIS_RST_MASK);
      // Read-only identity bytes ignore writes
      for (int i = 0; i < 4; i++) begin
         host.wr(8'(i + 2), 8'hFF);
         rchk(8'(i + 2), ro_exp[i]);
      end
      // Tool version bytes held independently
      for (int i = 0; i < 3; i++) begin
         host.wr(8'(i + 6), tool_val[i]);
      end
      for (int i = 0; i < 3; i++) begin
         rchk(8'(i + 6), tool_val[i]);
      end
      // Temperature class and package code are plain stored bytes
      host.wr(`PIS_OFF_TEMP, 8'h3C);
      rchk(`PIS_OFF_TEMP, 8'h3C);
      host.wr(`PIS_OFF_PKG, 8'h02);
      rchk(`PIS_OFF_PKG, 8'h02);
      // Target address: bit 7 dropped, low bits from straps
      host.wr(`PIS_OFF_TADDR, 8'hFF);
      rchk(`PIS_OFF_TADDR, 8'h7F);
      for (int p = 0; p < 4; p++) begin
         pins = 2'(p);
         @(posedge clk);
         #1;
         chk({1'b0, bus_addr}, {1'b0, 5'h1F, 2'(p)});
      end
      host.aim(`PIS_OFF_TADDR);
      @(posedge clk);
      #1;
      chk({7'h00, reg_burnable}, 8'h00);
      // Live status, sticky flags and masks
      for (int i = 0; i < 4; i++) begin
         bit_v = 8'h01 << pos[i];
         cond[i] = 1'b1;
         @(posedge clk);
         #1;
         rchk(`PIS_OFF_STATUS, bit_v);
         rchk(`PIS_OFF_FLAGS, bit_v);
         chk({7'h00, irq_n}, 8'h00);
         host.wr(`PIS_OFF_FLAGS, 8'h00);
         rchk(`PIS_OFF_FLAGS, bit_v);
         cond[i] = 1'b0;
         @(posedge clk);
         #1;
         rchk(`PIS_OFF_STATUS, 8'h00);
         rchk(`PIS_OFF_FLAGS, bit_v);
         host.wr(`PIS_OFF_MASK, 8'hC0 | bit_v);
         chk({7'h00, irq_n}, 8'h01);
         host.wr(`PIS_OFF_MASK, 8'hC0);
         chk({7'h00, irq_n}, 8'h00);
         host.wr(`PIS_OFF_FLAGS, ~bit_v);
         rchk(`PIS_OFF_FLAGS, 8'h00);
         chk({7'h00, irq_n}, 8'h01);
      end
      // Top page: only the page register answers
      host.wr(`PIS_OFF_PAGE, 8'hFF);
      chk(page_sel, 8'hFF);
      rchk(`PIS_OFF_PAGE, 8'hFF);
      rchk(`PIS_OFF_SPEED, 8'h00);
      host.wr(`PIS_OFF_TOOL0, 8'h11);
      host.aim(`PIS_OFF_TADDR);
      @(posedge clk);
      #1;
      chk({7'h00, reg_burnable}, 8'h01);
      host.wr(`PIS_OFF_PAGE, 8'h00);
      rchk(`PIS_OFF_TOOL0, 8'hA5);
      rchk(`PIS_OFF_PAGE, 8'h00);
      // Unmapped offset reads zero
      host.wr(8'h0D, 8'hFF);
      rchk(8'h0D, `PIS_READ_ZERO);
      // Second reset in mid-run
      host.wr(`PIS_OFF_PAGE, 8'h05);
      rst = 1'b1;
      @(posedge clk);
      #1;
      rst = 1'b0;
      rchk(`PIS_OFF_PAGE, 8'h00);
      rchk(`PIS_OFF_TOOL0, `PIS_RST_TOOL);
      print_verdict();
   end
endmodule
